/* hw/led_slot_defs.svh */
/*
  Register offsets, field positions, reset values and decode codes for the
  slot routing and third emitter driver current registers.
  Assumes inclusion by bare name from the design files.
*/
`ifndef LED_SLOT_DEFS_SVH
`define LED_SLOT_DEFS_SVH

`define ADDR_SLOT_SELECT 8'h14
`define ADDR_THIRD_CURRENT 8'h22
`define ADDR_FINE_CURRENT 8'h25

`define SLOT_SELECT_RESET 16'h0541
`define THIRD_CURRENT_RESET 16'h3000
`define FINE_CURRENT_RESET 16'h0000

`define FIRST_DIODE_EN_RESET 2'h2
`define SECOND_DIODE_EN_RESET 2'h1
`define FIRST_EMIT_EN_RESET 3'h1
`define SECOND_EMIT_EN_RESET 3'h0
`define FIRST_RESERVED_RESET 1'h0
`define SECOND_RESERVED_RESET 1'h1
`define LOW_POWER_RESET 1'h0
`define SLEW_RESET 3'h0
`define COARSE_RESET 4'h0

`define SLOT_SELECT_WMASK 16'h0FFF
`define THIRD_CURRENT_WMASK 16'h207F
`define THIRD_CURRENT_FORCE 16'h1000

`define SEC_DIODE_HI 11
`define SEC_DIODE_LO 8
`define FIRST_DIODE_HI 7
`define FIRST_DIODE_LO 4
`define SEC_EMIT_HI 3
`define SEC_EMIT_LO 2
`define FIRST_EMIT_HI 1
`define FIRST_EMIT_LO 0
`define SCALE_BIT 13
`define SLEW_HI 6
`define SLEW_LO 4
`define COARSE_HI 3
`define COARSE_LO 0
`define FINE_HI 15
`define FINE_LO 11

`define DIODE_ALL 4'h1
`define DIODE_UPPER 4'h4
`define DIODE_LOWER 4'h5

`define COARSE_BASE_MILLI 32'd28000
`define COARSE_STEP_MILLI 32'd15460
`define FINE_BASE_MILLI 32'd710
`define FINE_STEP_MILLI 32'd24
`define SCALE_LOW_MILLI 32'd400
`define SCALE_FULL_MILLI 32'd1000

`endif

/* hw/led_slot_pkg.sv */
/*
  Types shared by the slot routing register bank.
  Assumes nothing beyond the defines header.
*/
package led_slot_pkg;
  typedef enum logic [1:0]
  {
    EMIT_RESERVED = 2'b00,
    EMIT_ONE = 2'b01,
    EMIT_TWO = 2'b10,
    EMIT_THREE = 2'b11
  } emitter_sel_t;
endpackage

/* hw/slot_route_decode.sv */
/*
  Decodes one slot's diode and emitter codes into connection enables.
  Assumes codes come straight from configuration flip-flops.
*/
`timescale 1ns/10ps
`default_nettype none
`include "led_slot_defs.svh"
module slot_route_decode
  import led_slot_pkg::*;
(
  input wire logic [3:0] i_diode_code,
  input wire logic [1:0] i_emit_code,
  output logic [1:0] o_diode_group_en,
  output logic [2:0] o_emit_en,
  output logic o_code_reserved
);
  logic diode_bad;
  always_comb
  begin
    // Bit 0 lower four inputs, bit 1 upper four
    case (i_diode_code)
      `DIODE_ALL: o_diode_group_en = 2'h3;
      `DIODE_UPPER: o_diode_group_en = 2'h2;
      `DIODE_LOWER: o_diode_group_en = 2'h1;
      default: o_diode_group_en = 2'h0;
    endcase
    diode_bad = (o_diode_group_en == 2'h0);
    case (emitter_sel_t'(i_emit_code))
      EMIT_ONE: o_emit_en = 3'h1;
      EMIT_TWO: o_emit_en = 3'h2;
      EMIT_THREE: o_emit_en = 3'h4;
      default: o_emit_en = 3'h0;
    endcase
    o_code_reserved = diode_bad | (o_emit_en == 3'h0);
  end
endmodule
`default_nettype wire

/* hw/led_slot_config_regs.sv */
/*
  Slot routing and third emitter driver current register bank.
  Assumes a serial interface front end on the same clock delivering one-cycle
  write strobes and a read address; read data is registered.
*/
`timescale 1ns/10ps
`default_nettype none
`include "led_slot_defs.svh"
module led_slot_config_regs
  import led_slot_pkg::*;
(
  input wire logic i_mclk,
  input wire logic i_resetn,
  input wire logic i_wr_en,
  input wire logic i_rd_en,
  input wire logic [7:0] i_addr,
  input wire logic [15:0] i_wdata,
  output logic [15:0] o_rdata,
  output logic o_rvalid,
  output logic [1:0] o_first_diode_group_en,
  output logic [1:0] o_second_diode_group_en,
  output logic [2:0] o_first_emit_en,
  output logic [2:0] o_second_emit_en,
  output logic o_first_code_reserved,
  output logic o_second_code_reserved,
  output logic o_third_driver_low_power,
  output logic [2:0] o_third_driver_slew,
  output logic [3:0] o_third_driver_coarse_current,
  output logic [31:0] o_third_driver_peak_micro
);
  logic [15:0] slot_select_reg;
  logic [15:0] third_current_reg;
  logic [15:0] fine_current_reg;
  logic [15:0] rdata_reg;
  logic rvalid_reg;
  logic [31:0] peak_reg;
  logic [31:0] coarse_milli;
  logic [31:0] fine_milli;
  logic [31:0] scale_milli;
  logic [63:0] peak_next;
  logic [1:0] first_diode_dec;
  logic [1:0] second_diode_dec;
  logic [2:0] first_emit_dec;
  logic [2:0] second_emit_dec;
  logic first_reserved_dec;
  logic second_reserved_dec;
  logic [1:0] first_diode_reg;
  logic [1:0] second_diode_reg;
  logic [2:0] first_emit_reg;
  logic [2:0] second_emit_reg;
  logic first_reserved_reg;
  logic second_reserved_reg;
  logic low_power_reg;
  logic [2:0] slew_reg;
  logic [3:0] coarse_reg;

  // ----------------------------------------
  // Register writes
  // ----------------------------------------
  always_ff @(posedge i_mclk)
  begin
    if (!i_resetn)
      slot_select_reg <= `SLOT_SELECT_RESET;
    else if (i_wr_en && i_addr == `ADDR_SLOT_SELECT)
      slot_select_reg <= i_wdata & `SLOT_SELECT_WMASK;
  end

  always_ff @(posedge i_mclk)
  begin
    if (!i_resetn)
      third_current_reg <= `THIRD_CURRENT_RESET;
    else if (i_wr_en && i_addr == `ADDR_THIRD_CURRENT)
      third_current_reg <= (i_wdata & `THIRD_CURRENT_WMASK) | `THIRD_CURRENT_FORCE;
  end

  always_ff @(posedge i_mclk)
  begin
    if (!i_resetn)
      fine_current_reg <= `FINE_CURRENT_RESET;
    else if (i_wr_en && i_addr == `ADDR_FINE_CURRENT)
      fine_current_reg <= i_wdata;
  end

  // ----------------------------------------
  // Register reads
  // ----------------------------------------
  always_ff @(posedge i_mclk)
  begin
    if (!i_resetn)
    begin
      rdata_reg <= 16'h0000;
      rvalid_reg <= 1'b0;
    end
    else
    begin
      rvalid_reg <= i_rd_en;
      if (i_rd_en)
      begin
        case (i_addr)
          `ADDR_SLOT_SELECT: rdata_reg <= slot_select_reg;
          `ADDR_THIRD_CURRENT: rdata_reg <= third_current_reg;
          `ADDR_FINE_CURRENT: rdata_reg <= fine_current_reg;
          default: rdata_reg <= 16'h0000;
        endcase
      end
    end
  end

  assign o_rdata = rdata_reg;
  assign o_rvalid = rvalid_reg;

  // ----------------------------------------
  // Slot routing
  // ----------------------------------------
  slot_route_decode u_first_slot
  (
    .i_diode_code(slot_select_reg[`FIRST_DIODE_HI:`FIRST_DIODE_LO]),
    .i_emit_code(slot_select_reg[`FIRST_EMIT_HI:`FIRST_EMIT_LO]),
    .o_diode_group_en(first_diode_dec),
    .o_emit_en(first_emit_dec),
    .o_code_reserved(first_reserved_dec)
  );

  slot_route_decode u_second_slot
  (
    .i_diode_code(slot_select_reg[`SEC_DIODE_HI:`SEC_DIODE_LO]),
    .i_emit_code(slot_select_reg[`SEC_EMIT_HI:`SEC_EMIT_LO]),
    .o_diode_group_en(second_diode_dec),
    .o_emit_en(second_emit_dec),
    .o_code_reserved(second_reserved_dec)
  );

  // ----------------------------------------
  // Third driver settings
  // ----------------------------------------
  // Terms in thousandths; product scaled down to microamps
  always_comb
  begin
    coarse_milli = `COARSE_BASE_MILLI
      + `COARSE_STEP_MILLI * {28'h0000000, third_current_reg[`COARSE_HI:`COARSE_LO]};
    fine_milli = `FINE_BASE_MILLI
      + `FINE_STEP_MILLI * {27'h0000000, fine_current_reg[`FINE_HI:`FINE_LO]};
    scale_milli = third_current_reg[`SCALE_BIT] ? `SCALE_FULL_MILLI : `SCALE_LOW_MILLI;
    peak_next = ({32'h00000000, coarse_milli} * {32'h00000000, fine_milli}
      * {32'h00000000, scale_milli}) / 64'h00000000000F4240;
  end

  always_ff @(posedge i_mclk)
  begin
    if (!i_resetn)
      peak_reg <= 32'h00000000;
    else
      peak_reg <= peak_next[31:0];
  end

  assign o_third_driver_peak_micro = peak_reg;

  // ----------------------------------------
  // Registered outputs, one edge behind the registers
  // ----------------------------------------
  always_ff @(posedge i_mclk)
  begin
    if (!i_resetn)
    begin
      first_diode_reg <= `FIRST_DIODE_EN_RESET;
      first_emit_reg <= `FIRST_EMIT_EN_RESET;
      first_reserved_reg <= `FIRST_RESERVED_RESET;
    end
    else
    begin
      first_diode_reg <= first_diode_dec;
      first_emit_reg <= first_emit_dec;
      first_reserved_reg <= first_reserved_dec;
    end
  end

  always_ff @(posedge i_mclk)
  begin
    if (!i_resetn)
    begin
      second_diode_reg <= `SECOND_DIODE_EN_RESET;
      second_emit_reg <= `SECOND_EMIT_EN_RESET;
      second_reserved_reg <= `SECOND_RESERVED_RESET;
    end
    else
    begin
      second_diode_reg <= second_diode_dec;
      second_emit_reg <= second_emit_dec;
      second_reserved_reg <= second_reserved_dec;
    end
  end

  always_ff @(posedge i_mclk)
  begin
    if (!i_resetn)
    begin
      low_power_reg <= `LOW_POWER_RESET;
      slew_reg <= `SLEW_RESET;
      coarse_reg <= `COARSE_RESET;
    end
    else
    begin
      low_power_reg <= ~third_current_reg[`SCALE_BIT];
      slew_reg <= third_current_reg[`SLEW_HI:`SLEW_LO];
      coarse_reg <= third_current_reg[`COARSE_HI:`COARSE_LO];
    end
  end

  assign o_first_diode_group_en = first_diode_reg;
  assign o_second_diode_group_en = second_diode_reg;
  assign o_first_emit_en = first_emit_reg;
  assign o_second_emit_en = second_emit_reg;
  assign o_first_code_reserved = first_reserved_reg;
  assign o_second_code_reserved = second_reserved_reg;
  assign o_third_driver_low_power = low_power_reg;
  assign o_third_driver_slew = slew_reg;
  assign o_third_driver_coarse_current = coarse_reg;
endmodule
`default_nettype wire

/* tb/led_slot_chk.sv */
/* Port checks of the slot routing register bank.
   Assumes binding onto led_slot_config_regs. */
`timescale 1ns/10ps
`default_nettype none
module led_slot_chk (
  input wire logic i_mclk,
  input wire logic i_resetn,
  input wire logic i_wr_en,
  input wire logic i_rd_en,
  input wire logic [7:0] i_addr,
  input wire logic [15:0] i_wdata,
  input wire logic [15:0] o_rdata,
  input wire logic o_rvalid,
  input wire logic [1:0] o_first_diode_group_en,
  input wire logic [1:0] o_second_diode_group_en,
  input wire logic [2:0] o_first_emit_en,
  input wire logic [2:0] o_second_emit_en,
  input wire logic o_third_driver_low_power,
  input wire logic [2:0] o_third_driver_slew,
  input wire logic [3:0] o_third_driver_coarse_current
);
  // ----------------
  // Write and read effects
  // ----------------
  default clocking @(posedge i_mclk); endclocking
  default disable iff (!i_resetn);
  wire logic w14 = i_wr_en && i_addr == 8'h14;
  wire logic w22 = i_wr_en && i_addr == 8'h22;
  chk_second_diode_all: assert property (
    w14 && i_wdata[11:8] == 4'h1 |-> ##2 o_second_diode_group_en == 2'h3)
    else $error("diode b");
  chk_first_diode_upper: assert property (
    w14 && i_wdata[7:4] == 4'h4 |-> ##2 o_first_diode_group_en == 2'h2)
    else $error("diode a");
  chk_second_emit_map: assert property (
    w14 |-> ##2 o_second_emit_en == 3'((4'h1 << $past(i_wdata[3:2], 2)) >> 1))
    else $error("emit b");
  chk_first_emit_map: assert property (
    w14 |-> ##2 o_first_emit_en == 3'((4'h1 << $past(i_wdata[1:0], 2)) >> 1))
    else $error("emit a");
  chk_read_reserved: assert property (
    i_rd_en && i_addr == 8'h22 |=> o_rvalid && o_rdata[15:14] == 2'h0 && o_rdata[12])
    else $error("rsv");
  chk_scale_power: assert property (
    w22 |-> ##2 o_third_driver_low_power != $past(i_wdata[13], 2)) else $error("scale");
  chk_slew_value: assert property (
    w22 |-> ##2 o_third_driver_slew == $past(i_wdata[6:4], 2)) else $error("slew");
  chk_coarse_value: assert property (
    w22 |-> ##2 o_third_driver_coarse_current == $past(i_wdata[3:0], 2))
    else $error("coarse");
  cover property (w14);
  cover property (w22 && !i_wdata[13] ##2 o_third_driver_low_power);
  cover property (i_rd_en ##1 o_rvalid);
endmodule
bind led_slot_config_regs led_slot_chk u_led_slot_chk (.*);
`default_nettype wire

/* tb/led_slot_host.sv */
/* Host model issuing register writes and reads.
   Assumes the bank's clock and one access at a time. */
`timescale 1ns/10ps
`default_nettype none
module led_slot_host (
  input wire logic i_mclk,
  input wire logic [15:0] i_rdata,
  input wire logic i_rvalid,
  output logic o_wr_en = 1'h0,
  output logic o_rd_en = 1'h0,
  output logic [7:0] o_addr = 8'h0,
  output logic [15:0] o_wdata = 16'h0
);
  // ----------------
  // Access tasks
  // ----------------
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge i_mclk);
    o_wr_en <= 1'h1;
    o_addr <= a;
    o_wdata <= a == 8'h14 ? d & 16'h0FFF : a == 8'h22 ? d & 16'h207F | 16'h1000 : d;
    @(posedge i_mclk);
    o_wr_en <= 1'h0;
    o_wdata <= ~o_wdata;
  endtask
  task automatic rd(input logic [7:0] a, output logic [15:0] d, output logic v);
    @(posedge i_mclk);
    o_rd_en <= 1'h1;
    o_addr <= a;
    @(posedge i_mclk);
    o_rd_en <= 1'h0;
    @(posedge i_mclk);
    v = i_rvalid;
    d = i_rdata;
  endtask
endmodule
`default_nettype wire

/* tb/led_slot_config_regs_test.sv */
/* Self-checking bench of the slot routing register bank.
   Assumes host model and checker compiled before it. */
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin error_cnt++; \
  $display("ERROR %s exp %0h got %0h", n, e, g); end end
module led_slot_config_regs_test;
  logic i_mclk = 1'h0;
  logic i_resetn = 1'h0;
  logic wr, rd, rv, v, fr, sr, lp;
  logic [7:0] a;
  logic [15:0] wd, rdat, d;
  logic [1:0] fd, sd;
  logic [2:0] fe, se, sl;
  logic [3:0] co;
  logic [31:0] pk;
  longint pe;
  int error_cnt = 0;
  int samples_checked = 0;
  logic [3:0] dc [4] = '{4'h1, 4'h4, 4'h5, 4'h2};
  logic [15:0] cw [2] = '{16'h107F, 16'h3005};
  logic [4:0] fw [2] = '{5'h1F, 5'h01};
  always #50 i_mclk = ~i_mclk;
  led_slot_host u_led_slot_host (.i_mclk, .i_rdata(rdat), .i_rvalid(rv), .o_wr_en(wr),
    .o_rd_en(rd), .o_addr(a), .o_wdata(wd));
  led_slot_config_regs u_led_slot_config_regs (.i_mclk, .i_resetn, .i_wr_en(wr), .i_rd_en(rd),
    .i_addr(a), .i_wdata(wd), .o_rdata(rdat), .o_rvalid(rv), .o_first_diode_group_en(fd),
    .o_second_diode_group_en(sd), .o_first_emit_en(fe), .o_second_emit_en(se),
    .o_first_code_reserved(fr), .o_second_code_reserved(sr), .o_third_driver_low_power(lp),
    .o_third_driver_slew(sl), .o_third_driver_coarse_current(co), .o_third_driver_peak_micro(pk));
  function automatic logic [1:0] grp(input logic [3:0] c);
    return c == 4'h1 ? 2'h3 : c == 4'h4 ? 2'h2 : c == 4'h5 ? 2'h1 : 2'h0;
  endfunction
  task automatic tally_and_finish;
    $display("errors %0d checks %0d", error_cnt, samples_checked);
    if (error_cnt == 0 && samples_checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // ----------------
  // Scenarios
  // ----------------
  initial
  begin
    #1000000;
    error_cnt++;
    tally_and_finish();
  end
  initial
  begin
    repeat (4) @(posedge i_mclk);
    i_resetn <= 1'h1;
    u_led_slot_host.rd(8'h14, d, v);
    `CHK("slot reset", 17'h10541, {v, d})
    `CHK("emit reset", 6'h01, {se, fe})
    `CHK("route reset", 6'h1A, {sd, fd, sr, fr})
    `CHK("driver reset", 8'h00, {lp, sl, co})
    u_led_slot_host.rd(8'h22, d, v);
    `CHK("current reset", 17'h13000, {v, d})
    `CHK("peak reset", 32'h00004DA8, pk)
    for (int i = 0; i < 4; i++)
    begin
      u_led_slot_host.wr(8'h14, {4'h0, dc[i], dc[3 - i], 2'(i), 2'(3 - i)});
      repeat (2) @(negedge i_mclk);
      `CHK("diode b", grp(dc[i]), sd)
      `CHK("diode a", grp(dc[3 - i]), fd)
      `CHK("emit b", 3'((4'h1 << i) >> 1), se)
      `CHK("emit a", 3'((4'h1 << (3 - i)) >> 1), fe)
      `CHK("reserved", {2{i % 3 == 0}}, {sr, fr})
    end
    for (int i = 0; i < 2; i++)
    begin
      u_led_slot_host.wr(8'h25, {fw[i], 11'h0});
      u_led_slot_host.wr(8'h22, cw[i]);
      repeat (2) @(negedge i_mclk);
      pe = (28000 + 15460 * cw[i][3:0]) * (710 + 24 * fw[i]) * (cw[i][13] ? 1000 : 400);
      pe = pe / 1000000;
      `CHK("low power", ~cw[i][13], lp)
      `CHK("slew", cw[i][6:4], sl)
      `CHK("coarse", cw[i][3:0], co)
      `CHK("peak", pe[31:0], pk)
    end
    u_led_slot_host.wr(8'h30, 16'hFFFF);
    u_led_slot_host.rd(8'h30, d, v);
    `CHK("unmapped", 17'h10000, {v, d})
    u_led_slot_host.rd(8'h14, d, v);
    `CHK("slot kept", 17'h1021C, {v, d})
    @(posedge i_mclk);
    i_resetn <= 1'h0;
    repeat (2) @(posedge i_mclk);
    i_resetn <= 1'h1;
    u_led_slot_host.rd(8'h14, d, v);
    `CHK("slot re-reset", 17'h10541, {v, d})
    `CHK("route re-reset", 12'h606, {sd, fd, se, fe, sr, fr})
    `CHK("driver re-reset", 8'h00, {lp, sl, co})
    `CHK("peak re-reset", 32'h00004DA8, pk)
    tally_and_finish();
  end
endmodule
`default_nettype wire
